// File: hdl/tpp_pkg.sv
// Constants shared by the timer, pointer and power register bank.
package tpp_pkg;

	// Register addresses on the core's direct address port.
	localparam logic [7:0] ADDR_PTR_LOW  = 8'h84;
	localparam logic [7:0] ADDR_PTR_HIGH = 8'h85;
	localparam logic [7:0] ADDR_PTR_SEL  = 8'h86;
	localparam logic [7:0] ADDR_POWER    = 8'h87;
	localparam logic [7:0] ADDR_TCTRL    = 8'h88;
	localparam logic [7:0] ADDR_TMODE    = 8'h89;
	localparam logic [7:0] ADDR_T0_LOW   = 8'h8A;
	localparam logic [7:0] ADDR_T1_LOW   = 8'h8B;
	localparam logic [7:0] ADDR_T0_HIGH  = 8'h8C;
	localparam logic [7:0] ADDR_T1_HIGH  = 8'h8D;
	localparam logic [7:0] ADDR_CLKCTRL  = 8'h8E;
	localparam logic [7:0] ADDR_PORT1    = 8'h90;

	// Values after reset, the value read at unmapped addresses and the unused power bits.
	localparam logic [7:0] RST_BYTE      = 8'h00;
	localparam logic [7:0] RST_CLKCTRL   = 8'h01;
	localparam logic [7:0] RST_PORT1     = 8'hFF;
	localparam logic [7:0] READ_UNMAPPED = 8'hFF;
	localparam logic [7:0] POWER_UNUSED  = 8'h30;

	// Power control bit positions.
	localparam int unsigned PWR_BAUD_DBL  = 7;
	localparam int unsigned PWR_FE_EN     = 6;
	localparam int unsigned PWR_POWERDOWN = 1;
	localparam int unsigned PWR_SLEEP     = 0;

	// Timer control bit positions.
	localparam int unsigned TC_TF1 = 7;
	localparam int unsigned TC_TR1 = 6;
	localparam int unsigned TC_TF0 = 5;
	localparam int unsigned TC_TR0 = 4;
	localparam int unsigned TC_IE1 = 3;
	localparam int unsigned TC_IT1 = 2;
	localparam int unsigned TC_IE0 = 1;
	localparam int unsigned TC_IT0 = 0;

	// Timer mode field positions; timer 1 fields sit four bits higher.
	localparam int unsigned TM_MODE_LSB = 0;
	localparam int unsigned TM_COUNTER  = 2;
	localparam int unsigned TM_GATE     = 3;
	localparam int unsigned TM_T1_SHIFT = 4;

	localparam logic [1:0] MODE_PRESCALED = 2'h0;
	localparam logic [1:0] MODE_FULL      = 2'h1;
	localparam logic [1:0] MODE_RELOAD    = 2'h2;
	localparam logic [1:0] MODE_SPLIT     = 2'h3;

	// Clock control bit positions.
	localparam int unsigned CK_WD_LSB  = 6;
	localparam int unsigned CK_T2_DIV  = 5;
	localparam int unsigned CK_T1_DIV  = 4;
	localparam int unsigned CK_T0_DIV  = 3;
	localparam int unsigned CK_STR_LSB = 0;

	// Timer clock dividers: divide by 12 and divide by 4 of the core clock.
	localparam logic [3:0] PRESCALE_LAST = 4'hB;
	localparam logic [1:0] DIV4_PHASE    = 2'h3;

	// Watchdog timeouts as powers of two, and the reset margin in clocks.
	localparam logic [4:0]  WD_EXP_0     = 5'h11;
	localparam logic [4:0]  WD_EXP_1     = 5'h14;
	localparam logic [4:0]  WD_EXP_2     = 5'h17;
	localparam logic [4:0]  WD_EXP_3     = 5'h1A;
	localparam logic [31:0] WD_RST_EXTRA = 32'h0000_0200;

	// External data move length in machine cycles.
	localparam logic [3:0] EXTERNAL_DATA_MOVE_BASE   = 4'h2;
	localparam logic [3:0] EXTERNAL_DATA_MOVE_ONCHIP = 4'h2;

	// Pins passed through the synchroniser.
	localparam int unsigned SYNC_WIDTH = 12;

endpackage

// File: hdl/tpp_pin_sync.sv
// Two-stage synchroniser for the pins read by the register bank.
`timescale 1ns/100ps
module tpp_pin_sync
	import tpp_pkg::*;
(
	input  wire logic                  i_core_clk,
	input  wire logic                  i_sys_rst,
	input  wire logic [SYNC_WIDTH-1:0] i_pins,
	output logic      [SYNC_WIDTH-1:0] o_pins
);

	typedef struct packed
	{
		logic [SYNC_WIDTH-1:0] stage1;
		logic [SYNC_WIDTH-1:0] stage2;
	} tpp_sync_state_type;

	tpp_sync_state_type s;
	tpp_sync_state_type next_s;

	always_comb
	begin
		next_s.stage1 = i_pins;
		next_s.stage2 = s.stage1;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_sys_rst)
			s <= '1;
		else
			s <= next_s;
	end

	assign o_pins = s.stage2;

endmodule

// File: hdl/tpp_sfr_bank.sv
// Register bank for the second data pointer, power control, timers 0/1 and clock control.
`timescale 1ns/100ps
module tpp_sfr_bank
	import tpp_pkg::*;
(
	input  wire logic        i_core_clk,
	input  wire logic        i_sys_rst,
	input  wire logic [7:0]  i_sfr_addr,
	input  wire logic        i_sfr_wr,
	input  wire logic [7:0]  i_sfr_wdata,
	input  wire logic        i_sfr_rd,
	input  wire logic        i_sfr_rmw,
	output logic      [7:0]  o_sfr_rdata,
	input  wire logic [15:0] i_first_pointer,
	output logic      [15:0] o_active_data_pointer,
	output logic             o_pointer_select,
	output logic             o_baud_doubler,
	output logic             o_frame_error_enable,
	output logic             o_power_down,
	output logic             o_cpu_clock_stop,
	input  wire logic        i_wake,
	input  wire logic        i_timer0_vector,
	input  wire logic        i_timer1_vector,
	input  wire logic        i_ext0_vector,
	input  wire logic        i_ext1_vector,
	input  wire logic        i_external_request_pin_zero_n,
	input  wire logic        i_external_request_pin_one_n,
	input  wire logic        i_timer0_count_pin,
	input  wire logic        i_timer1_count_pin,
	output logic             o_timer0_overflow_flag,
	output logic             o_timer1_overflow_flag,
	output logic             o_ext_request0_flag,
	output logic             o_ext_request1_flag,
	output logic             o_timer2_tick,
	output logic      [31:0] o_watchdog_irq_cycles,
	output logic      [31:0] o_watchdog_reset_cycles,
	input  wire logic        i_external_data_move_onchip,
	output logic      [3:0]  o_external_data_move_cycles,
	input  wire logic [7:0]  i_port1_pins,
	output logic      [7:0]  o_port_one_latch
);

	typedef struct packed
	{
		logic [7:0] ptr_low;
		logic [7:0] ptr_high;
		logic       ptr_sel;
		logic [7:0] power;
		logic [7:0] tctrl;
		logic [7:0] tmode;
		logic [7:0] t0_low;
		logic [7:0] t0_high;
		logic [7:0] t1_low;
		logic [7:0] t1_high;
		logic [7:0] clkctrl;
		logic [7:0] port1;
		logic [3:0] prescale;
		logic [3:0] pin_prev;
		logic [7:0] rdata;
	} tpp_bank_state_type;

	tpp_bank_state_type s;
	tpp_bank_state_type next_s;

	logic [SYNC_WIDTH-1:0] pins;
	logic                  tick12;
	logic                  tick4;
	logic                  halted;
	logic                  fall_t0;
	logic                  fall_t1;
	logic                  fall_x0;
	logic                  fall_x1;
	logic [1:0]            mode0;
	logic [1:0]            mode1;
	logic                  base0;
	logic                  base1;
	logic                  inc0;
	logic                  inc1;
	logic                  inc0_high;
	logic [16:0]           step0;
	logic [16:0]           step1;
	logic [4:0]            wd_exp;

	// Steps a timer in modes 0, 1 and 2; result is overflow, high byte, low byte.
	function automatic logic [16:0] tpp_step(input logic [1:0] mode,
		input logic [7:0] lo, input logic [7:0] hi);
		logic [12:0] c13;
		logic [15:0] c16;
		logic [7:0]  c8;
		c13 = {hi, lo[4:0]} + 13'h0001;
		c16 = {hi, lo} + 16'h0001;
		c8  = lo + 8'h01;
		unique case (mode)
			MODE_PRESCALED:
				tpp_step = {({hi, lo[4:0]} == 13'h1FFF), c13[12:5], lo[7:5], c13[4:0]};
			MODE_FULL:
				tpp_step = {({hi, lo} == 16'hFFFF), c16};
			MODE_RELOAD, MODE_SPLIT:
				tpp_step = {(lo == 8'hFF), hi, (lo == 8'hFF) ? hi : c8};
		endcase
	endfunction

	tpp_pin_sync i_tpp_pin_sync
	(
		.i_core_clk (i_core_clk),
		.i_sys_rst  (i_sys_rst),
		.i_pins     ({i_port1_pins, i_timer1_count_pin, i_timer0_count_pin,
			i_external_request_pin_one_n, i_external_request_pin_zero_n}),
		.o_pins     (pins)
	);

	// Power-down freezes every clock the bank uses; sleep leaves timers running.
	assign halted  = s.power[PWR_POWERDOWN];
	assign tick12  = ~halted & (s.prescale == PRESCALE_LAST);
	assign tick4   = ~halted & (s.prescale[1:0] == DIV4_PHASE);
	assign fall_x0 = s.pin_prev[0] & ~pins[0];
	assign fall_x1 = s.pin_prev[1] & ~pins[1];
	assign fall_t0 = ~halted & s.pin_prev[2] & ~pins[2];
	assign fall_t1 = ~halted & s.pin_prev[3] & ~pins[3];

	assign mode0 = s.tmode[TM_MODE_LSB +: 2];
	assign mode1 = s.tmode[TM_T1_SHIFT + TM_MODE_LSB +: 2];
	assign base0 = s.clkctrl[CK_T0_DIV] ? tick4 : tick12;
	assign base1 = s.clkctrl[CK_T1_DIV] ? tick4 : tick12;

	// Count enable: run bit, optional gate on the request pin, then the source.
	assign inc0 = s.tctrl[TC_TR0]
		& (~s.tmode[TM_GATE] | pins[0])
		& (s.tmode[TM_COUNTER] ? fall_t0 : base0);
	assign inc1 = s.tctrl[TC_TR1]
		& (~s.tmode[TM_T1_SHIFT + TM_GATE] | pins[1])
		& (s.tmode[TM_T1_SHIFT + TM_COUNTER] ? fall_t1 : base1)
		& (mode1 != MODE_SPLIT);
	assign inc0_high = s.tctrl[TC_TR1] & base0;

	assign step0 = tpp_step(mode0, s.t0_low, s.t0_high);
	assign step1 = tpp_step(mode1, s.t1_low, s.t1_high);

	always_comb
	begin
		next_s = s;
		next_s.pin_prev = pins[3:0];
		next_s.prescale = halted ? s.prescale :
			((s.prescale == PRESCALE_LAST) ? 4'h0 : s.prescale + 4'h1);

		// Sleep and power-down end when the core signals a wake-up event.
		if (i_wake)
		begin
			next_s.power[PWR_POWERDOWN] = 1'b0;
			next_s.power[PWR_SLEEP] = 1'b0;
		end

		// Timer counting; a software write to a counter in the same cycle wins.
		if (mode0 == MODE_SPLIT)
		begin
			if (inc0)
				next_s.t0_low = s.t0_low + 8'h01;
			if (inc0_high)
				next_s.t0_high = s.t0_high + 8'h01;
		end
		else if (inc0)
		begin
			next_s.t0_low = step0[7:0];
			next_s.t0_high = step0[15:8];
		end
		if (inc1)
		begin
			next_s.t1_low = step1[7:0];
			next_s.t1_high = step1[15:8];
		end

		if (i_sfr_wr)
		begin
			unique case (i_sfr_addr)
				ADDR_PTR_LOW:  next_s.ptr_low = i_sfr_wdata;
				ADDR_PTR_HIGH: next_s.ptr_high = i_sfr_wdata;
				ADDR_PTR_SEL:  next_s.ptr_sel = i_sfr_wdata[0];
				ADDR_POWER:    next_s.power = i_sfr_wdata & ~POWER_UNUSED;
				ADDR_TCTRL:    next_s.tctrl = i_sfr_wdata;
				ADDR_TMODE:    next_s.tmode = i_sfr_wdata;
				ADDR_T0_LOW:   next_s.t0_low = i_sfr_wdata;
				ADDR_T1_LOW:   next_s.t1_low = i_sfr_wdata;
				ADDR_T0_HIGH:  next_s.t0_high = i_sfr_wdata;
				ADDR_T1_HIGH:  next_s.t1_high = i_sfr_wdata;
				ADDR_CLKCTRL:  next_s.clkctrl = i_sfr_wdata;
				ADDR_PORT1:    next_s.port1 = i_sfr_wdata;
				default:       next_s.port1 = next_s.port1;
			endcase
		end

		// Vectoring clears the overflow flags; an overflow in that cycle still sets.
		if (i_timer0_vector)
			next_s.tctrl[TC_TF0] = 1'b0;
		if (i_timer1_vector)
			next_s.tctrl[TC_TF1] = 1'b0;
		if (mode0 == MODE_SPLIT)
		begin
			if (inc0 && (s.t0_low == 8'hFF))
				next_s.tctrl[TC_TF0] = 1'b1;
			if (inc0_high && (s.t0_high == 8'hFF))
				next_s.tctrl[TC_TF1] = 1'b1;
		end
		else if (inc0 && step0[16])
			next_s.tctrl[TC_TF0] = 1'b1;
		if (inc1 && step1[16] && (mode0 != MODE_SPLIT))
			next_s.tctrl[TC_TF1] = 1'b1;

		// External request flags: edge mode sets on a falling edge, level mode follows.
		if (next_s.tctrl[TC_IT0])
		begin
			if (i_ext0_vector)
				next_s.tctrl[TC_IE0] = 1'b0;
			if (fall_x0)
				next_s.tctrl[TC_IE0] = 1'b1;
		end
		else
			next_s.tctrl[TC_IE0] = ~pins[0];
		if (next_s.tctrl[TC_IT1])
		begin
			if (i_ext1_vector)
				next_s.tctrl[TC_IE1] = 1'b0;
			if (fall_x1)
				next_s.tctrl[TC_IE1] = 1'b1;
		end
		else
			next_s.tctrl[TC_IE1] = ~pins[1];

		// Read data is captured on the read strobe and shown the next cycle.
		if (i_sfr_rd)
		begin
			unique case (i_sfr_addr)
				ADDR_PTR_LOW:  next_s.rdata = s.ptr_low;
				ADDR_PTR_HIGH: next_s.rdata = s.ptr_high;
				ADDR_PTR_SEL:  next_s.rdata = {7'h00, s.ptr_sel};
				ADDR_POWER:    next_s.rdata = s.power | POWER_UNUSED;
				ADDR_TCTRL:    next_s.rdata = s.tctrl;
				ADDR_TMODE:    next_s.rdata = s.tmode;
				ADDR_T0_LOW:   next_s.rdata = s.t0_low;
				ADDR_T1_LOW:   next_s.rdata = s.t1_low;
				ADDR_T0_HIGH:  next_s.rdata = s.t0_high;
				ADDR_T1_HIGH:  next_s.rdata = s.t1_high;
				ADDR_CLKCTRL:  next_s.rdata = s.clkctrl;
				ADDR_PORT1:    next_s.rdata = i_sfr_rmw ? s.port1 : pins[11:4];
				default:       next_s.rdata = READ_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_sys_rst)
		begin
			s          <= '0;
			s.ptr_low  <= RST_BYTE;
			s.ptr_high <= RST_BYTE;
			s.power    <= RST_BYTE;
			s.tctrl    <= RST_BYTE;
			s.tmode    <= RST_BYTE;
			s.clkctrl  <= RST_CLKCTRL;
			s.port1    <= RST_PORT1;
			s.pin_prev <= 4'hF;
			s.rdata    <= RST_BYTE;
		end
		else
			s <= next_s;
	end

	// Watchdog period selection.
	always_comb
	begin
		unique case (s.clkctrl[CK_WD_LSB +: 2])
			2'h0: wd_exp = WD_EXP_0;
			2'h1: wd_exp = WD_EXP_1;
			2'h2: wd_exp = WD_EXP_2;
			2'h3: wd_exp = WD_EXP_3;
		endcase
	end

	assign o_watchdog_irq_cycles   = 32'h0000_0001 << wd_exp;
	assign o_watchdog_reset_cycles = o_watchdog_irq_cycles + WD_RST_EXTRA;

	// External data move length.
	assign o_external_data_move_cycles = i_external_data_move_onchip ? EXTERNAL_DATA_MOVE_ONCHIP
		: {1'b0, s.clkctrl[CK_STR_LSB +: 3]} + EXTERNAL_DATA_MOVE_BASE;

	assign o_sfr_rdata            = s.rdata;
	assign o_pointer_select       = s.ptr_sel;
	assign o_active_data_pointer  = s.ptr_sel ? {s.ptr_high, s.ptr_low} : i_first_pointer;
	assign o_baud_doubler         = s.power[PWR_BAUD_DBL];
	assign o_frame_error_enable   = s.power[PWR_FE_EN];
	assign o_power_down           = s.power[PWR_POWERDOWN];
	assign o_cpu_clock_stop       = s.power[PWR_POWERDOWN] | s.power[PWR_SLEEP];
	assign o_timer0_overflow_flag = s.tctrl[TC_TF0];
	assign o_timer1_overflow_flag = s.tctrl[TC_TF1];
	assign o_ext_request0_flag    = s.tctrl[TC_IE0];
	assign o_ext_request1_flag    = s.tctrl[TC_IE1];
	assign o_timer2_tick          = s.clkctrl[CK_T2_DIV] ? tick4 : tick12;
	assign o_port_one_latch       = s.port1;

endmodule

// File: verification/tpp_sfr_bank_sva.sv
// Checker for the timer, pointer and power register bank.
`timescale 1ns/100ps
module tpp_sfr_bank_sva
	import tpp_pkg::*;
(
	input  wire logic        i_core_clk,
	input  wire logic        i_sys_rst,
	input  wire logic [7:0]  i_sfr_addr,
	input  wire logic        i_sfr_wr,
	input  wire logic [7:0]  i_sfr_wdata,
	input  wire logic        i_sfr_rd,
	input  wire logic        i_sfr_rmw,
	input  wire logic [7:0]  o_sfr_rdata,
	input  wire logic [15:0] i_first_pointer,
	input  wire logic [15:0] o_active_data_pointer,
	input  wire logic        o_pointer_select,
	input  wire logic        o_power_down,
	input  wire logic        o_cpu_clock_stop,
	input  wire logic        o_timer0_overflow_flag,
	input  wire logic        o_timer2_tick,
	input  wire logic [31:0] o_watchdog_irq_cycles,
	input  wire logic [31:0] o_watchdog_reset_cycles,
	input  wire logic        i_external_data_move_onchip,
	input  wire logic [3:0]  o_external_data_move_cycles,
	input  wire logic [7:0]  o_port_one_latch
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_sys_rst);
	sequence s_rd(logic [7:0] a);
		i_sfr_rd && i_sfr_addr == a;
	endsequence
	sequence s_wr(logic [7:0] a);
		i_sfr_wr && i_sfr_addr == a;
	endsequence
	chk_ptr_first: assert property (!o_pointer_select |-> o_active_data_pointer == i_first_pointer)
		else $error("first pointer not passed through");
	chk_sel_write: assert property (s_wr(ADDR_PTR_SEL) |=> o_pointer_select == $past(i_sfr_wdata[0]))
		else $error("select bit not written");
	chk_sel_read: assert property (s_rd(ADDR_PTR_SEL) |=> o_sfr_rdata == {7'h00, $past(o_pointer_select)})
		else $error("select readback wrong");
	chk_power_write: assert property (s_wr(ADDR_POWER) |=>
		o_power_down == $past(i_sfr_wdata[1])
		&& o_cpu_clock_stop == (|$past(i_sfr_wdata[1:0])))
		else $error("power request not applied");
	chk_power_read: assert property (s_rd(ADDR_POWER) |=>
		o_sfr_rdata[5:4] == 2'h3 && o_sfr_rdata[1] == $past(o_power_down))
		else $error("power readback wrong");
	chk_flag_read: assert property (s_rd(ADDR_TCTRL) |=> o_sfr_rdata[5] == $past(o_timer0_overflow_flag))
		else $error("overflow flag readback wrong");
	chk_down_stop: assert property (o_power_down |-> !o_timer2_tick && o_cpu_clock_stop)
		else $error("clock runs in power-down");
	chk_wd_margin: assert property (
		o_watchdog_reset_cycles == o_watchdog_irq_cycles + 32'h200
		&& $onehot(o_watchdog_irq_cycles))
		else $error("watchdog timeouts wrong");
	chk_external_data_move_chip: assert property (i_external_data_move_onchip |-> o_external_data_move_cycles == 4'h2)
		else $error("on-chip move not two cycles");
	chk_external_data_move_range: assert property (!i_external_data_move_onchip |-> o_external_data_move_cycles inside {[4'h2:4'h9]})
		else $error("move length out of range");
	chk_port_rmw: assert property (s_rd(ADDR_PORT1) ##0 i_sfr_rmw |=> o_sfr_rdata == $past(o_port_one_latch))
		else $error("port latch not returned");
endmodule
bind tpp_sfr_bank tpp_sfr_bank_sva i_tpp_sfr_bank_sva (
	.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_sfr_addr(i_sfr_addr),
	.i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata), .i_sfr_rd(i_sfr_rd),
	.i_sfr_rmw(i_sfr_rmw), .o_sfr_rdata(o_sfr_rdata), .i_first_pointer(i_first_pointer),
	.o_active_data_pointer(o_active_data_pointer), .o_pointer_select(o_pointer_select),
	.o_power_down(o_power_down), .o_cpu_clock_stop(o_cpu_clock_stop),
	.o_timer0_overflow_flag(o_timer0_overflow_flag), .o_timer2_tick(o_timer2_tick),
	.o_watchdog_irq_cycles(o_watchdog_irq_cycles), .o_external_data_move_cycles(o_external_data_move_cycles),
	.o_watchdog_reset_cycles(o_watchdog_reset_cycles), .i_external_data_move_onchip(i_external_data_move_onchip),
	.o_port_one_latch(o_port_one_latch)
);

// File: verification/tpp_sfr_bank_tb.sv
// Self-checking testbench for the timer, pointer and power register bank.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module tpp_sfr_bank_tb;
	import tpp_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rmw = 1'b0, wake = 1'b0;
	logic        v0 = 1'b0, e0v = 1'b0, p0n = 1'b1, c0 = 1'b1, onc = 1'b0;
	logic [7:0]  addr = 8'h00, wd = 8'h00, pins = 8'hA5, rdata, latch, d;
	logic [15:0] fp = 16'h1234, adp;
	logic        sel, bd, fee, pd, cs, tf0, tf1, ef0, ef1, t2t;
	logic [31:0] wdi, wdr;
	logic [3:0]  mvc;
	int          n_fail = 0, checks = 0, cyc = 0, n;
	logic [7:0]  ra [12] = '{8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8A, 8'h8B,
		8'h8C, 8'h8D, 8'h8E, 8'h90};
	logic [7:0]  rv [12] = '{8'h00, 8'h00, 8'h00, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h01, 8'hFF};
	logic [7:0]  thi [3] = '{8'hFF, 8'hFF, 8'hF0};
	logic [7:0]  tli [3] = '{8'h1E, 8'hFE, 8'hFE};
	logic [7:0]  the [3] = '{8'h00, 8'h00, 8'hF0};
	logic [7:0]  tle [3] = '{8'h00, 8'h00, 8'hF0};
	always #5 clk = ~clk;
	tpp_sfr_bank i_tpp_sfr_bank (
		.i_core_clk(clk), .i_sys_rst(rst), .i_sfr_addr(addr), .i_sfr_wr(wr),
		.i_sfr_wdata(wd), .i_sfr_rd(rd), .i_sfr_rmw(rmw), .o_sfr_rdata(rdata),
		.i_first_pointer(fp), .o_active_data_pointer(adp), .o_pointer_select(sel),
		.o_baud_doubler(bd), .o_frame_error_enable(fee), .o_power_down(pd),
		.o_cpu_clock_stop(cs), .i_wake(wake), .i_timer0_vector(v0), .i_timer1_vector(1'b0),
		.i_ext0_vector(e0v), .i_ext1_vector(1'b0), .i_external_request_pin_zero_n(p0n),
		.i_external_request_pin_one_n(1'b1), .i_timer0_count_pin(c0),
		.i_timer1_count_pin(1'b1), .o_timer0_overflow_flag(tf0),
		.o_timer1_overflow_flag(tf1), .o_ext_request0_flag(ef0), .o_ext_request1_flag(ef1),
		.o_timer2_tick(t2t), .o_watchdog_irq_cycles(wdi), .o_watchdog_reset_cycles(wdr),
		.i_external_data_move_onchip(onc), .o_external_data_move_cycles(mvc), .i_port1_pins(pins),
		.o_port_one_latch(latch)
	);
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		addr = a;
		wd = v;
		wr = 1'b1;
		step(1);
		wr = 1'b0;
		step(1);
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic m, output logic [7:0] v);
		addr = a;
		rmw = m;
		rd = 1'b1;
		step(1);
		v = rdata;
		rd = 1'b0;
		rmw = 1'b0;
		step(1);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic m, input logic [7:0] e);
		logic [7:0] v;
		rd_reg(a, m, v);
		`CHK("readback", e, v)
	endtask
	task automatic complete_run();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_fail++;
			complete_run();
		end
	end
	initial
	begin
		step(8);
		rst = 1'b0;
		step(4);
		for (int i = 0; i < 12; i++)
			rd_chk(ra[i], 1'b1, rv[i]);
		rd_chk(8'h8F, 1'b0, READ_UNMAPPED);
		wr_reg(ADDR_PTR_LOW, 8'hA5);
		wr_reg(ADDR_PTR_HIGH, 8'h5A);
		rd_chk(ADDR_PTR_LOW, 1'b0, 8'hA5);
		rd_chk(ADDR_PTR_HIGH, 1'b0, 8'h5A);
		wr_reg(ADDR_PTR_SEL, 8'hFF);
		rd_chk(ADDR_PTR_SEL, 1'b0, 8'h01);
		`CHK("pointer", 16'h5AA5, adp)
		wr_reg(ADDR_PTR_SEL, 8'h00);
		`CHK("pointer", fp, adp)
		wr_reg(ADDR_POWER, 8'hCC);
		rd_chk(ADDR_POWER, 1'b0, 8'hFC);
		`CHK("doubler", 2'h3, {bd, fee})
		`CHK("no stop", 2'h0, {pd, cs})
		for (int i = 1; i < 3; i++)
		begin
			wr_reg(ADDR_POWER, i[7:0]);
			`CHK("stop", {i[1], 1'b1}, {pd, cs})
			wake = 1'b1;
			step(1);
			wake = 1'b0;
			`CHK("wake", 2'h0, {pd, cs})
		end
		for (int w = 0; w < 4; w++)
		begin
			wr_reg(ADDR_CLKCTRL, {w[1:0], 6'h00});
			`CHK("wd irq", 32'h1 << (17 + 3 * w), wdi)
			`CHK("wd rst", (32'h1 << (17 + 3 * w)) + 32'h200, wdr)
		end
		wr_reg(ADDR_CLKCTRL, 8'h20);
		n = 0;
		repeat (24)
		begin
			if (t2t === 1'b1)
				n++;
			step(1);
		end
		`CHK("t2 ticks", 6, n)
		for (int s = 0; s < 8; s++)
		begin
			wr_reg(ADDR_CLKCTRL, s[7:0]);
			`CHK("external_data_move", s[3:0] + 4'h2, mvc)
			onc = 1'b1;
			step(1);
			`CHK("external_data_move chip", 4'h2, mvc)
			onc = 1'b0;
		end
		for (int m = 0; m < 3; m++)
		begin
			wr_reg(ADDR_TCTRL, 8'h00);
			wr_reg(ADDR_CLKCTRL, 8'h08);
			wr_reg(ADDR_TMODE, m[7:0]);
			wr_reg(ADDR_T0_HIGH, thi[m]);
			wr_reg(ADDR_T0_LOW, tli[m]);
			wr_reg(ADDR_TCTRL, 8'h10);
			n = 0;
			while (tf0 !== 1'b1 && n < 20)
			begin
				step(1);
				n++;
			end
			`CHK("div4 time", 1'b1, n >= 4 && n <= 9)
			rd_chk(ADDR_T0_LOW, 1'b0, tle[m]);
			rd_chk(ADDR_T0_HIGH, 1'b0, the[m]);
			v0 = 1'b1;
			step(1);
			v0 = 1'b0;
			`CHK("vector", 1'b0, tf0)
		end
		wr_reg(ADDR_TCTRL, 8'h00);
		rd_reg(ADDR_T0_LOW, 1'b0, d);
		step(20);
		rd_chk(ADDR_T0_LOW, 1'b0, d);
		wr_reg(ADDR_TMODE, 8'h01);
		wr_reg(ADDR_CLKCTRL, 8'h00);
		wr_reg(ADDR_T0_LOW, 8'h00);
		wr_reg(ADDR_TCTRL, 8'h10);
		step(118);
		wr_reg(ADDR_TCTRL, 8'h00);
		rd_chk(ADDR_T0_LOW, 1'b0, 8'h0A);
		wr_reg(ADDR_TMODE, 8'h09);
		wr_reg(ADDR_CLKCTRL, 8'h08);
		wr_reg(ADDR_T0_LOW, 8'h00);
		p0n = 1'b0;
		step(4);
		`CHK("level", 1'b1, ef0)
		wr_reg(ADDR_TCTRL, 8'h10);
		step(40);
		rd_chk(ADDR_T0_LOW, 1'b0, 8'h00);
		e0v = 1'b1;
		step(1);
		e0v = 1'b0;
		`CHK("level vector", 1'b1, ef0)
		p0n = 1'b1;
		step(40);
		`CHK("level follow", 1'b0, ef0)
		rd_reg(ADDR_T0_LOW, 1'b0, d);
		`CHK("gate open", 1'b1, d !== 8'h00)
		wr_reg(ADDR_TCTRL, 8'h01);
		p0n = 1'b0;
		step(6);
		p0n = 1'b1;
		step(6);
		`CHK("edge", 1'b1, ef0)
		e0v = 1'b1;
		step(1);
		e0v = 1'b0;
		`CHK("edge vector", 1'b0, ef0)
		wr_reg(ADDR_TMODE, 8'h05);
		wr_reg(ADDR_T0_LOW, 8'h00);
		wr_reg(ADDR_TCTRL, 8'h10);
		repeat (5)
		begin
			c0 = 1'b0;
			step(4);
			c0 = 1'b1;
			step(4);
		end
		wr_reg(ADDR_TCTRL, 8'h00);
		rd_chk(ADDR_T0_LOW, 1'b0, 8'h05);
		wr_reg(ADDR_TCTRL, 8'hA0);
		`CHK("sw flags", 2'h3, {tf1, tf0})
		rd_chk(ADDR_TCTRL, 1'b0, 8'hA0);
		wr_reg(ADDR_PORT1, 8'h3C);
		`CHK("latch", 8'h3C, latch)
		rd_chk(ADDR_PORT1, 1'b0, 8'hA5);
		rd_chk(ADDR_PORT1, 1'b1, 8'h3C);
		complete_run();
	end
endmodule
